// ===== fifo_mark_ctrl.sv
`timescale 1ns/1ns
// ----------------------------------------
// Watermark and indirect pointer control
// ----------------------------------------
module fifo_mark_ctrl
	import fifo_mark_pkg::*;
(
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              rst,
	// Register port
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wr_data,
	input  wire logic              wr_en,
	input  wire logic              rd_en,
	output logic      [DATA_W-1:0] rd_data,
	// Receive HDLC block completions
	input  wire logic              rx_blk_valid,
	output logic                   rx_blk_ready,
	input  wire chan_evt_t         rx_blk,
	// Receive DMA requests
	output logic                   rx_dma_valid,
	output logic      [CH_W-1:0]   rx_dma_ch,
	// Transmit HDLC block reads
	input  wire logic              tx_rd_valid,
	output logic                   tx_rd_ready,
	input  wire logic [CH_W-1:0]   tx_rd_ch,
	// Transmit DMA block fills
	input  wire logic              tx_fill_valid,
	output logic                   tx_fill_ready,
	input  wire chan_evt_t         tx_fill,
	// Transmit DMA requests and HDLC release
	output logic                   tx_dma_valid,
	output logic      [CH_W-1:0]   tx_dma_ch,
	output logic                   tx_go_valid,
	output logic      [CH_W-1:0]   tx_go_ch
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	eng_state_t       state_r, state_nxt;
	host_op_t         op_r, op_nxt;
	logic [CH_W-1:0]  ch_r, ch_nxt;
	logic             eof_r, eof_nxt;
	logic [BLK_W-1:0] hwm_lat_r;
	logic [BLK_W-1:0] cnt_lat_r;

	logic [CH_W-1:0]  start_sel_r;
	logic             start_dir_r;
	logic             start_busy_r;
	logic [BLK_W-1:0] start_data_r;
	logic [BLK_W-1:0] link_sel_r;
	logic             link_dir_r;
	logic             link_busy_r;
	logic [BLK_W-1:0] link_data_r;
	logic [CH_W-1:0]  hwm_sel_r;
	logic             hwm_dir_r;
	logic             hwm_busy_r;
	logic [BLK_W-1:0] hwm_data_r;
	logic [BLK_W-1:0] tx_low_r;
	logic [DATA_W-1:0] rd_data_r;

	logic             done_start, done_link, done_hwm;
	logic             rx_fire_now, tx_refill_now, tx_release_now;

	logic             st_we, st_re;
	logic [CH_W-1:0]  st_waddr, st_raddr;
	logic [BLK_W-1:0] st_wdata, st_rdata;
	logic             lk_we, lk_re;
	logic [BLK_W-1:0] lk_waddr, lk_raddr, lk_wdata, lk_rdata;
	logic             hw_we, hw_re;
	logic [CH_W-1:0]  hw_waddr, hw_raddr;
	logic [BLK_W-1:0] hw_wdata, hw_rdata;
	logic             rc_we, rc_re;
	logic [CH_W-1:0]  rc_waddr, rc_raddr;
	logic [BLK_W-1:0] rc_wdata, rc_rdata;
	logic             tc_we, tc_re;
	logic [CH_W-1:0]  tc_waddr, tc_raddr;
	logic [TXW_W-1:0] tc_wdata, tc_rdata;

	logic [BLK_W-1:0] rx_cnt_nxt;
	logic             rx_fire;
	logic [TXW_W-1:0] tx_rd_word_nxt, tx_fill_word_nxt;
	logic             tx_refill, tx_release;

	// ----------------------------------------
	// Tables
	// ----------------------------------------
	// Per-channel current block, advanced as data flows
	block_ram #(.W(BLK_W), .D(CH_NUM), .AW(CH_W)) start_tab (
		.clock(clock), .rst(rst), .we(st_we), .waddr(st_waddr), .wdata(st_wdata),
		.re(st_re), .raddr(st_raddr), .rdata(st_rdata));
	// Per-block next-block link
	block_ram #(.W(BLK_W), .D(BLK_NUM), .AW(BLK_W)) link_tab (
		.clock(clock), .rst(rst), .we(lk_we), .waddr(lk_waddr), .wdata(lk_wdata),
		.re(lk_re), .raddr(lk_raddr), .rdata(lk_rdata));
	// Per-channel receive high mark
	block_ram #(.W(BLK_W), .D(CH_NUM), .AW(CH_W)) hwm_tab (
		.clock(clock), .rst(rst), .we(hw_we), .waddr(hw_waddr), .wdata(hw_wdata),
		.re(hw_re), .raddr(hw_raddr), .rdata(hw_rdata));
	// Per-channel receive successive block count
	block_ram #(.W(BLK_W), .D(CH_NUM), .AW(CH_W)) rx_cnt_tab (
		.clock(clock), .rst(rst), .we(rc_we), .waddr(rc_waddr), .wdata(rc_wdata),
		.re(rc_re), .raddr(rc_raddr), .rdata(rc_rdata));
	// Per-channel transmit fill count and release flag
	block_ram #(.W(TXW_W), .D(CH_NUM), .AW(CH_W)) tx_cnt_tab (
		.clock(clock), .rst(rst), .we(tc_we), .waddr(tc_waddr), .wdata(tc_wdata),
		.re(tc_re), .raddr(tc_raddr), .rdata(tc_rdata));

	// Decisions
	mark_judge judge (
		.rx_cnt(cnt_lat_r),
		.rx_hwm(hwm_lat_r),
		.rx_eof(eof_r),
		.rx_cnt_nxt(rx_cnt_nxt),
		.rx_fire(rx_fire),
		.tx_word(tc_rdata),
		.tx_low(tx_low_r),
		.tx_eof(eof_r),
		.tx_rd_word_nxt(tx_rd_word_nxt),
		.tx_refill(tx_refill),
		.tx_fill_word_nxt(tx_fill_word_nxt),
		.tx_release(tx_release)
	);

	// ----------------------------------------
	// Engine sequencing
	// ----------------------------------------
	// Host indirect access first, then receive, transmit read, transmit fill
	always_comb begin
		state_nxt = state_r;
		op_nxt = op_r;
		ch_nxt = ch_r;
		eof_nxt = eof_r;
		done_start = 1'b0;
		done_link = 1'b0;
		done_hwm = 1'b0;
		rx_fire_now = 1'b0;
		tx_refill_now = 1'b0;
		tx_release_now = 1'b0;
		rx_blk_ready = 1'b0;
		tx_rd_ready = 1'b0;
		tx_fill_ready = 1'b0;
		st_we = 1'b0; st_re = 1'b0; st_waddr = CH_ZERO; st_raddr = CH_ZERO;
		st_wdata = BLK_ZERO;
		lk_we = 1'b0; lk_re = 1'b0; lk_waddr = BLK_ZERO; lk_raddr = BLK_ZERO;
		lk_wdata = BLK_ZERO;
		hw_we = 1'b0; hw_re = 1'b0; hw_waddr = CH_ZERO; hw_raddr = CH_ZERO;
		hw_wdata = BLK_ZERO;
		rc_we = 1'b0; rc_re = 1'b0; rc_waddr = CH_ZERO; rc_raddr = CH_ZERO;
		rc_wdata = BLK_ZERO;
		tc_we = 1'b0; tc_re = 1'b0; tc_waddr = CH_ZERO; tc_raddr = CH_ZERO;
		tc_wdata = '0;
		case (state_r)
			ST_IDLE: begin
				if (start_busy_r) begin
					op_nxt = OP_START;
					if (start_dir_r == DIR_WRITE) begin
						st_we = 1'b1;
						st_waddr = start_sel_r;
						st_wdata = start_data_r;
						rc_we = 1'b1;
						rc_waddr = start_sel_r;
						// New chain starts with an empty transmit count too
						tc_we = 1'b1;
						tc_waddr = start_sel_r;
						done_start = 1'b1;
					end else begin
						st_re = 1'b1;
						st_raddr = start_sel_r;
						state_nxt = ST_HOST_RD;
					end
				end else if (link_busy_r) begin
					op_nxt = OP_LINK;
					if (link_dir_r == DIR_WRITE) begin
						lk_we = 1'b1;
						lk_waddr = link_sel_r;
						lk_wdata = link_data_r;
						done_link = 1'b1;
					end else begin
						lk_re = 1'b1;
						lk_raddr = link_sel_r;
						state_nxt = ST_HOST_RD;
					end
				end else if (hwm_busy_r) begin
					op_nxt = OP_HWM;
					if (hwm_dir_r == DIR_WRITE) begin
						hw_we = 1'b1;
						hw_waddr = hwm_sel_r;
						hw_wdata = hwm_data_r;
						done_hwm = 1'b1;
					end else begin
						hw_re = 1'b1;
						hw_raddr = hwm_sel_r;
						state_nxt = ST_HOST_RD;
					end
				end else if (rx_blk_valid) begin
					rx_blk_ready = 1'b1;
					ch_nxt = rx_blk.ch;
					eof_nxt = rx_blk.eof;
					st_re = 1'b1;
					st_raddr = rx_blk.ch;
					hw_re = 1'b1;
					hw_raddr = rx_blk.ch;
					rc_re = 1'b1;
					rc_raddr = rx_blk.ch;
					state_nxt = ST_RX_LINK;
				end else if (tx_rd_valid) begin
					tx_rd_ready = 1'b1;
					ch_nxt = tx_rd_ch;
					eof_nxt = 1'b0;
					tc_re = 1'b1;
					tc_raddr = tx_rd_ch;
					state_nxt = ST_TX_RD;
				end else if (tx_fill_valid) begin
					tx_fill_ready = 1'b1;
					ch_nxt = tx_fill.ch;
					eof_nxt = tx_fill.eof;
					tc_re = 1'b1;
					tc_raddr = tx_fill.ch;
					state_nxt = ST_TX_FILL;
				end
			end
			ST_HOST_RD: begin
				done_start = (op_r == OP_START);
				done_link = (op_r == OP_LINK);
				done_hwm = (op_r == OP_HWM);
				state_nxt = ST_IDLE;
			end
			ST_RX_LINK: begin
				// Follow the chain from the block just completed
				lk_re = 1'b1;
				lk_raddr = st_rdata;
				state_nxt = ST_RX_UPD;
			end
			ST_RX_UPD: begin
				st_we = 1'b1;
				st_waddr = ch_r;
				st_wdata = lk_rdata;
				rc_we = 1'b1;
				rc_waddr = ch_r;
				rc_wdata = rx_cnt_nxt;
				rx_fire_now = rx_fire;
				state_nxt = ST_IDLE;
			end
			ST_TX_RD: begin
				tc_we = 1'b1;
				tc_waddr = ch_r;
				tc_wdata = tx_rd_word_nxt;
				tx_refill_now = tx_refill;
				state_nxt = ST_IDLE;
			end
			ST_TX_FILL: begin
				tc_we = 1'b1;
				tc_waddr = ch_r;
				tc_wdata = tx_fill_word_nxt;
				tx_release_now = tx_release;
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// Engine state and event latches
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_r <= ST_IDLE;
			op_r <= OP_START;
			ch_r <= CH_ZERO;
			eof_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			op_r <= op_nxt;
			ch_r <= ch_nxt;
			eof_r <= eof_nxt;
		end
	end

	// Receive mark and count captured after the first table read
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			hwm_lat_r <= BLK_ZERO;
			cnt_lat_r <= BLK_ZERO;
		end else if (state_r == ST_RX_LINK) begin
			hwm_lat_r <= hw_rdata;
			cnt_lat_r <= rc_rdata;
		end
	end

	// ----------------------------------------
	// DMA request and release outputs
	// ----------------------------------------
	// One-cycle pulses; the DMA drains or fills the whole channel
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rx_dma_valid <= 1'b0;
			rx_dma_ch <= CH_ZERO;
			tx_dma_valid <= 1'b0;
			tx_dma_ch <= CH_ZERO;
			tx_go_valid <= 1'b0;
			tx_go_ch <= CH_ZERO;
		end else begin
			rx_dma_valid <= rx_fire_now;
			tx_dma_valid <= tx_refill_now;
			tx_go_valid <= tx_release_now;
			if (rx_fire_now) begin
				rx_dma_ch <= ch_r;
			end
			if (tx_refill_now) begin
				tx_dma_ch <= ch_r;
			end
			if (tx_release_now) begin
				tx_go_ch <= ch_r;
			end
		end
	end

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	// Select, data and low-mark registers; selects ignored while busy
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			start_sel_r <= CH_ZERO;
			start_dir_r <= DIR_WRITE;
			start_busy_r <= 1'b0;
			start_data_r <= BLK_ZERO;
			link_sel_r <= BLK_ZERO;
			link_dir_r <= DIR_WRITE;
			link_busy_r <= 1'b0;
			link_data_r <= BLK_ZERO;
			hwm_sel_r <= CH_ZERO;
			hwm_dir_r <= DIR_WRITE;
			hwm_busy_r <= 1'b0;
			hwm_data_r <= BLK_ZERO;
			tx_low_r <= BLK_ONE;
		end else begin
			if (done_start) begin
				start_busy_r <= 1'b0;
			end
			if (done_link) begin
				link_busy_r <= 1'b0;
			end
			if (done_hwm) begin
				hwm_busy_r <= 1'b0;
			end
			if (done_start && start_dir_r == DIR_READ) begin
				start_data_r <= st_rdata;
			end
			if (done_link && link_dir_r == DIR_READ) begin
				link_data_r <= lk_rdata;
			end
			if (done_hwm && hwm_dir_r == DIR_READ) begin
				hwm_data_r <= hw_rdata;
			end
			if (wr_en) begin
				case (addr)
					OFS_START_SEL: if (!start_busy_r) begin
						start_sel_r <= wr_data[CH_W-1:0];
						start_dir_r <= wr_data[DIR_BIT];
						start_busy_r <= 1'b1;
					end
					OFS_START_DAT: start_data_r <= wr_data[BLK_W-1:0];
					OFS_LINK_SEL: if (!link_busy_r) begin
						link_sel_r <= wr_data[BLK_W-1:0];
						link_dir_r <= wr_data[DIR_BIT];
						link_busy_r <= 1'b1;
					end
					OFS_LINK_DAT: link_data_r <= wr_data[BLK_W-1:0];
					OFS_HWM_SEL: if (!hwm_busy_r) begin
						hwm_sel_r <= wr_data[CH_W-1:0];
						hwm_dir_r <= wr_data[DIR_BIT];
						hwm_busy_r <= 1'b1;
					end
					OFS_HWM_DAT: hwm_data_r <= wr_data[BLK_W-1:0];
					OFS_TX_LOW: tx_low_r <= wr_data[BLK_W-1:0];
					default: begin
					end
				endcase
			end
		end
	end

	// Read data one cycle after the strobe, zero elsewhere
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rd_data_r <= WORD_ZERO;
		end else if (rd_en) begin
			case (addr)
				OFS_START_SEL: rd_data_r <= sel_word(start_busy_r, start_dir_r,
					{2'b00, start_sel_r});
				OFS_START_DAT: rd_data_r <= {6'h00, start_data_r};
				OFS_LINK_SEL:  rd_data_r <= sel_word(link_busy_r, link_dir_r, link_sel_r);
				OFS_LINK_DAT:  rd_data_r <= {6'h00, link_data_r};
				OFS_HWM_SEL:   rd_data_r <= sel_word(hwm_busy_r, hwm_dir_r,
					{2'b00, hwm_sel_r});
				OFS_HWM_DAT:   rd_data_r <= {6'h00, hwm_data_r};
				OFS_TX_LOW:    rd_data_r <= {6'h00, tx_low_r};
				default:       rd_data_r <= WORD_ZERO;
			endcase
		end else begin
			rd_data_r <= WORD_ZERO;
		end
	end

	assign rd_data = rd_data_r;
endmodule

// ===== fifo_mark_pkg.sv
// Behaviour
// - Request receive DMA after high-mark count of successive complete blocks written.
// - Receive DMA request asks for a full drain, ignoring end-of-frame markers.
// - End-of-frame before the high mark still requests receive DMA at once.
// - Request transmit DMA when block reads leave low-mark blocks remaining.
// - Transmit DMA request asks to fill the channel completely across packets.
// - After refilling an empty transmit FIFO, release only above low mark or EOF.
// - Channel select is eight bits, zero means channel one, all ones 256.
// - Direction zero on start select writes start data into the selected channel.
// - Busy reads one during indirect access, clears when done or data ready.
// - Start pointer is ten bits naming any of 1024 receive blocks.
// - Reading start pointer returns the block currently being written for that channel.
// - Direction one on link select fetches the block entry, busy until data valid.
// - Direction zero on link select stores link data into the selected block.
// - Block select is ten bits, zero is block 0, all ones block 1023.
// - Internal logic may advance the stored start pointer as data flows.
// - High mark is a ten-bit block count; zero is invalid.
package fifo_mark_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int CH_W    = 8;
	localparam int BLK_W   = 10;
	localparam int DATA_W  = 16;
	localparam int ADDR_W  = 12;
	localparam int CH_NUM  = 256;
	localparam int BLK_NUM = 1024;
	localparam int TXW_W   = BLK_W + 1;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] OFS_START_SEL = 12'h0900;
	localparam logic [ADDR_W-1:0] OFS_START_DAT = 12'h0904;
	localparam logic [ADDR_W-1:0] OFS_LINK_SEL  = 12'h0910;
	localparam logic [ADDR_W-1:0] OFS_LINK_DAT  = 12'h0914;
	localparam logic [ADDR_W-1:0] OFS_HWM_SEL   = 12'h0920;
	localparam logic [ADDR_W-1:0] OFS_HWM_DAT   = 12'h0924;
	localparam logic [ADDR_W-1:0] OFS_TX_LOW    = 12'h09A0;

	// ----------------------------------------
	// Fields and reset values
	// ----------------------------------------
	localparam int BUSY_BIT = 15;
	localparam int DIR_BIT  = 14;
	localparam logic DIR_WRITE = 1'b0;
	localparam logic DIR_READ  = 1'b1;
	localparam int TX_PRIMED_BIT = BLK_W;
	localparam logic [BLK_W-1:0]  BLK_ZERO   = 10'h000;
	localparam logic [BLK_W-1:0]  BLK_ONE    = 10'h001;
	localparam logic [BLK_W-1:0]  BLK_MAX    = 10'h3FF;
	localparam logic [BLK_W-1:0]  HWM_INVALID = 10'h000;
	localparam logic [CH_W-1:0]   CH_ZERO    = 8'h00;
	localparam logic [DATA_W-1:0] WORD_ZERO  = 16'h0000;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic [CH_W-1:0] ch;
		logic            eof;
	} chan_evt_t;

	typedef enum logic [1:0] {
		OP_START = 2'b00,
		OP_LINK  = 2'b01,
		OP_HWM   = 2'b10
	} host_op_t;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_HOST_RD = 3'b001,
		ST_RX_LINK = 3'b010,
		ST_RX_UPD  = 3'b011,
		ST_TX_RD   = 3'b100,
		ST_TX_FILL = 3'b101
	} eng_state_t;

	// Select register read image
	function automatic logic [DATA_W-1:0] sel_word(input logic busy, input logic dir,
		input logic [BLK_W-1:0] field);
		logic [DATA_W-1:0] w;
		w = WORD_ZERO;
		w[BUSY_BIT] = busy;
		w[DIR_BIT] = dir;
		w[BLK_W-1:0] = field;
		return w;
	endfunction

endpackage

// ===== block_ram.sv
`timescale 1ns/1ns
// ----------------------------------------
// Simple dual-port table, registered read
// ----------------------------------------
module block_ram #(
	parameter int W  = 10,
	parameter int D  = 256,
	parameter int AW = 8
) (
	// Clock and reset
	input  wire logic          clock,
	input  wire logic          rst,
	// Write side
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [W-1:0]  wdata,
	// Read side
	input  wire logic          re,
	input  wire logic [AW-1:0] raddr,
	output logic      [W-1:0]  rdata
);
	logic [W-1:0] mem [D];

	// Storage write
	always_ff @(posedge clock) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Read data held until the next read
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rdata <= '0;
		end else if (re) begin
			rdata <= mem[raddr];
		end
	end
endmodule

// ===== mark_judge.sv
`timescale 1ns/1ns
// ----------------------------------------
// Watermark decisions for one event
// ----------------------------------------
module mark_judge
	import fifo_mark_pkg::*;
(
	// Receive side
	input  wire logic [BLK_W-1:0] rx_cnt,
	input  wire logic [BLK_W-1:0] rx_hwm,
	input  wire logic             rx_eof,
	output logic      [BLK_W-1:0] rx_cnt_nxt,
	output logic                  rx_fire,
	// Transmit side
	input  wire logic [TXW_W-1:0] tx_word,
	input  wire logic [BLK_W-1:0] tx_low,
	input  wire logic             tx_eof,
	output logic      [TXW_W-1:0] tx_rd_word_nxt,
	output logic                  tx_refill,
	output logic      [TXW_W-1:0] tx_fill_word_nxt,
	output logic                  tx_release
);
	logic [BLK_W-1:0] rx_inc;
	logic [BLK_W-1:0] tx_cnt;
	logic [BLK_W-1:0] tx_dec;
	logic [BLK_W-1:0] tx_inc;
	logic             primed_base;
	logic             primed_new;

	// Receive: count successive blocks, fire on mark or end of frame
	always_comb begin
		rx_inc = (rx_cnt == BLK_MAX) ? BLK_MAX : rx_cnt + BLK_ONE;
		rx_fire = rx_eof || ((rx_hwm != HWM_INVALID) && (rx_inc >= rx_hwm));
		rx_cnt_nxt = rx_fire ? BLK_ZERO : rx_inc;
	end

	// Transmit: reads drain, DMA fills, release gate for empty restart
	always_comb begin
		tx_cnt = tx_word[BLK_W-1:0];
		tx_dec = (tx_cnt == BLK_ZERO) ? BLK_ZERO : tx_cnt - BLK_ONE;
		tx_inc = (tx_cnt == BLK_MAX) ? BLK_MAX : tx_cnt + BLK_ONE;
		tx_refill = (tx_cnt != BLK_ZERO) && (tx_dec == tx_low);
		tx_rd_word_nxt = {tx_word[TX_PRIMED_BIT], tx_dec};
		primed_base = (tx_cnt == BLK_ZERO) ? 1'b0 : tx_word[TX_PRIMED_BIT];
		primed_new = primed_base || tx_eof || (tx_inc > tx_low);
		tx_release = primed_new && !primed_base;
		tx_fill_word_nxt = {primed_new, tx_inc};
	end
endmodule

// ===== fifo_mark_assertions.sv
`timescale 1ns/1ns
module fifo_mark_assertions
	import fifo_mark_pkg::*;
(
	// Clock and reset
	input wire logic              clock,
	input wire logic              rst,
	// Register port
	input wire logic              rd_en,
	input wire logic [DATA_W-1:0] rd_data,
	// Receive side
	input wire logic              rx_blk_valid,
	input wire logic              rx_blk_ready,
	input wire chan_evt_t         rx_blk,
	input wire logic              rx_dma_valid,
	input wire logic [CH_W-1:0]   rx_dma_ch,
	// Transmit side
	input wire logic              tx_rd_valid,
	input wire logic              tx_rd_ready,
	input wire logic              tx_fill_valid,
	input wire logic              tx_fill_ready,
	input wire logic              tx_dma_valid,
	input wire logic              tx_go_valid
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	logic            rx_acc;
	logic            tx_acc;
	logic            fill_acc;
	logic [CH_W-1:0] rx_ch;
	// Accepted transfers
	assign rx_acc = rx_blk_valid && rx_blk_ready;
	assign tx_acc = tx_rd_valid && tx_rd_ready;
	assign fill_acc = tx_fill_valid && tx_fill_ready;
	assign rx_ch = rx_blk.ch;
	// Engine busy two cycles after a receive accept
	sequence s_rx_hold;
		!rx_blk_ready ##1 !rx_blk_ready;
	endsequence
	rx_hold_a: assert property (rx_acc |=> s_rx_hold)
		else $error("receive ready not held low");
	rx_eof_a: assert property (rx_acc && rx_blk.eof |-> ##3 rx_dma_valid && rx_dma_ch == $past(rx_ch, 3))
		else $error("end of frame gave no drain request");
	rx_cause_a: assert property (rx_dma_valid |-> $past(rx_acc, 3))
		else $error("drain request without a block");
	rx_pulse_a: assert property (rx_dma_valid |=> !rx_dma_valid)
		else $error("drain request longer than one cycle");
	tx_cause_a: assert property (tx_dma_valid |-> $past(tx_acc, 2))
		else $error("refill request without a block read");
	tx_pulse_a: assert property (tx_dma_valid |=> !tx_dma_valid)
		else $error("refill request longer than one cycle");
	go_cause_a: assert property (tx_go_valid |-> $past(fill_acc, 2))
		else $error("release without a block fill");
	rd_idle_a: assert property (!rd_en |=> rd_data == 16'h0000)
		else $error("read data outside its cycle");
endmodule
bind fifo_mark_ctrl fifo_mark_assertions i_chk (.clock(clock), .rst(rst), .rd_en(rd_en),
	.rd_data(rd_data), .rx_blk_valid(rx_blk_valid), .rx_blk_ready(rx_blk_ready),
	.rx_blk(rx_blk), .rx_dma_valid(rx_dma_valid), .rx_dma_ch(rx_dma_ch),
	.tx_rd_valid(tx_rd_valid), .tx_rd_ready(tx_rd_ready), .tx_fill_valid(tx_fill_valid),
	.tx_fill_ready(tx_fill_ready), .tx_dma_valid(tx_dma_valid), .tx_go_valid(tx_go_valid));

// ===== hdlc_dma_model.sv
`timescale 1ns/1ns
module hdlc_dma_model
	import fifo_mark_pkg::*;
(
	// Clock
	input wire logic        clock,
	// Receive blocks
	output logic            rx_blk_valid,
	input wire logic        rx_blk_ready,
	output chan_evt_t       rx_blk,
	// Transmit reads and fills
	output logic            tx_rd_valid,
	input wire logic        tx_rd_ready,
	output logic [CH_W-1:0] tx_rd_ch,
	output logic            tx_fill_valid,
	input wire logic        tx_fill_ready,
	output chan_evt_t       tx_fill
);
	// Idle lines at start
	initial begin
		rx_blk_valid = 1'b0;
		rx_blk = '0;
		tx_rd_valid = 1'b0;
		tx_rd_ch = '0;
		tx_fill_valid = 1'b0;
		tx_fill = '0;
	end
	// Hold request until ready seen at a falling edge, then release after the next rising edge
	task automatic wait_rdy(input int k, output bit ok);
		logic r;
		ok = 0;
		for (int i = 0; i < 40 && !ok; i++) begin
			@(negedge clock);
			r = (k == 0) ? rx_blk_ready : (k == 1) ? tx_rd_ready : tx_fill_ready;
			ok = (r === 1'b1);
			@(posedge clock);
		end
	endtask
	// Released data lines show the inverse value
	task automatic rx_send(input logic [CH_W-1:0] c, input logic e, output bit ok);
		rx_blk_valid <= 1'b1;
		rx_blk <= {c, e};
		wait_rdy(0, ok);
		rx_blk_valid <= 1'b0;
		rx_blk <= ~{c, e};
	endtask
	task automatic tx_read(input logic [CH_W-1:0] c, output bit ok);
		tx_rd_valid <= 1'b1;
		tx_rd_ch <= c;
		wait_rdy(1, ok);
		tx_rd_valid <= 1'b0;
		tx_rd_ch <= ~c;
	endtask
	task automatic tx_put(input logic [CH_W-1:0] c, input logic e, output bit ok);
		tx_fill_valid <= 1'b1;
		tx_fill <= {c, e};
		wait_rdy(2, ok);
		tx_fill_valid <= 1'b0;
		tx_fill <= ~{c, e};
	endtask
endmodule

// ===== testbench.sv
`timescale 1ns/1ns
module testbench
	import fifo_mark_pkg::*;
;
	logic              clock = 1'b0;
	logic              rst = 1'b1;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wr_data = '0;
	logic              wr_en = 1'b0;
	logic              rd_en = 1'b0;
	logic [DATA_W-1:0] rd_data;
	logic              rx_blk_valid, rx_blk_ready, rx_dma_valid;
	chan_evt_t         rx_blk, tx_fill;
	logic [CH_W-1:0]   rx_dma_ch, tx_rd_ch, tx_dma_ch, tx_go_ch, dma_ch;
	logic              tx_rd_valid, tx_rd_ready, tx_fill_valid, tx_fill_ready;
	logic              tx_dma_valid, tx_go_valid;
	int                n_errors = 0;
	int                check_count = 0;
	int                n_dma = 0;
	int                n_txd = 0;
	int                n_go = 0;
	bit                ok;
	fifo_mark_ctrl i_dut (.clock(clock), .rst(rst), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .rx_blk_valid(rx_blk_valid),
		.rx_blk_ready(rx_blk_ready), .rx_blk(rx_blk), .rx_dma_valid(rx_dma_valid),
		.rx_dma_ch(rx_dma_ch), .tx_rd_valid(tx_rd_valid), .tx_rd_ready(tx_rd_ready),
		.tx_rd_ch(tx_rd_ch), .tx_fill_valid(tx_fill_valid), .tx_fill_ready(tx_fill_ready),
		.tx_fill(tx_fill), .tx_dma_valid(tx_dma_valid), .tx_dma_ch(tx_dma_ch),
		.tx_go_valid(tx_go_valid), .tx_go_ch(tx_go_ch));
	hdlc_dma_model i_peer (.clock(clock), .rx_blk_valid(rx_blk_valid),
		.rx_blk_ready(rx_blk_ready), .rx_blk(rx_blk), .tx_rd_valid(tx_rd_valid),
		.tx_rd_ready(tx_rd_ready), .tx_rd_ch(tx_rd_ch), .tx_fill_valid(tx_fill_valid),
		.tx_fill_ready(tx_fill_ready), .tx_fill(tx_fill));
	// Clock
	always #10 clock = ~clock;
	// Count drain, refill and release requests
	always @(posedge clock) begin
		if (rx_dma_valid === 1'b1) begin
			n_dma <= n_dma + 1;
			dma_ch <= rx_dma_ch;
		end
		if (tx_dma_valid === 1'b1) n_txd <= n_txd + 1;
		if (tx_go_valid === 1'b1) n_go <= n_go + 1;
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		rd_en <= 1'b0;
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clock);
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] q);
		wr_en <= 1'b0;
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clock);
		rd_en <= 1'b0;
		@(negedge clock);
		q = rd_data;
		@(posedge clock);
	endtask
	task automatic rc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		logic [DATA_W-1:0] q;
		rd(a, q);
		chk(q, exp);
	endtask
	task automatic poll(input logic [ADDR_W-1:0] a);
		logic [DATA_W-1:0] q;
		q = 16'h8000;
		for (int i = 0; i < 20 && q[BUSY_BIT] !== 1'b0; i++) rd(a, q);
		if (q[BUSY_BIT] !== 1'b0) begin
			n_errors++;
			end_sim();
		end
	endtask
	task automatic rxb(input logic [CH_W-1:0] c, input logic e, input int k = 0);
		if (k == 0) i_peer.rx_send(c, e, ok);
		else if (k == 1) i_peer.tx_read(c, ok);
		else i_peer.tx_put(c, e, ok);
		if (!ok) begin
			n_errors++;
			end_sim();
		end
		repeat (4) @(posedge clock);
	endtask
	task automatic end_sim();
		$display("checks=%0d mismatches=%0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		rc(OFS_START_SEL, 16'h0000);
		rc(OFS_LINK_SEL, 16'h0000);
		rc(OFS_TX_LOW, 16'h0001);
		rc(12'h09FC, 16'h0000);
		$display("test reset done");
		// Four-block chain 3,4,5,6 and the top block
		for (int i = 0; i < 5; i++) begin
			wr(OFS_LINK_DAT, (i < 4) ? 16'(3 + (i + 1) % 4) : 16'h0005);
			wr(OFS_LINK_SEL, (i < 4) ? 16'(3 + i) : 16'h03FF);
			poll(OFS_LINK_SEL);
		end
		wr(OFS_LINK_SEL, 16'h43FF);
		rc(OFS_LINK_SEL, 16'hC3FF);
		poll(OFS_LINK_SEL);
		rc(OFS_LINK_DAT, 16'h0005);
		wr(OFS_LINK_SEL, 16'h4004);
		wr(OFS_LINK_SEL, 16'h0006);
		poll(OFS_LINK_SEL);
		rc(OFS_LINK_SEL, 16'h4004);
		rc(OFS_LINK_DAT, 16'h0005);
		$display("test links done");
		// Channel 256 starts at block 3, high mark 3
		wr(OFS_START_DAT, 16'h0003);
		wr(OFS_START_SEL, 16'h00FF);
		poll(OFS_START_SEL);
		wr(OFS_HWM_DAT, 16'h0003);
		wr(OFS_HWM_SEL, 16'h00FF);
		poll(OFS_HWM_SEL);
		wr(OFS_HWM_SEL, 16'h40FF);
		poll(OFS_HWM_SEL);
		rc(OFS_HWM_DAT, 16'h0003);
		for (int i = 0; i < 3; i++) begin
			rxb(8'hFF, 1'b0);
			chk(16'(n_dma), (i == 2) ? 16'h0001 : 16'h0000);
		end
		chk({8'h00, dma_ch}, 16'h00FF);
		wr(OFS_START_SEL, 16'h40FF);
		poll(OFS_START_SEL);
		rc(OFS_START_DAT, 16'h0006);
		rxb(8'hFF, 1'b0);
		chk(16'(n_dma), 16'h0001);
		rxb(8'hFF, 1'b1);
		chk(16'(n_dma), 16'h0002);
		$display("test high mark done");
		// Channel 1 starts at block 1023
		wr(OFS_START_DAT, 16'h03FF);
		wr(OFS_START_SEL, 16'h0000);
		poll(OFS_START_SEL);
		rxb(8'h00, 1'b1);
		chk({8'h00, dma_ch}, 16'h0000);
		wr(OFS_START_SEL, 16'h4000);
		poll(OFS_START_SEL);
		rc(OFS_START_DAT, 16'h0005);
		$display("test channel one done");
		// Low mark register and transmit traffic
		wr(OFS_TX_LOW, 16'h0002);
		rc(OFS_TX_LOW, 16'h0002);
		for (int i = 0; i < 3; i++) begin
			rxb(8'hFF, 1'b0, 2);
			chk(16'(n_go), (i == 2) ? 16'h0001 : 16'h0000);
		end
		chk({8'h00, tx_go_ch}, 16'h00FF);
		for (int i = 0; i < 2; i++) begin
			rxb(8'hFF, 1'b0, 1);
			chk(16'(n_txd), 16'h0001);
		end
		chk({8'h00, tx_dma_ch}, 16'h00FF);
		rxb(8'h00, 1'b1, 2);
		chk(16'(n_go), 16'h0002);
		chk({8'h00, tx_go_ch}, 16'h0000);
		$display("test transmit done");
		end_sim();
	end
endmodule
